/* core/drive_status_relay_select.sv */
// Purpose: picks one internal drive condition and drives the output relay with it
// Assumes: all inputs synchronous to mclk; protective logic supplies the trip flags
// Notes:   register port answers reads one cycle later; one level interrupt output
//
// Implementation choices: strobed register access and the register offsets.
`include "relay_select_defs.svh"
`default_nettype none

// Behaviour
// R01 - relay follows exactly one source chosen by select code 0 to 17, default 17
// R02 - code 17 follows fault mask: bit0 DC low, bit1 other trips, bit2 restart set
// R03 - fault mask takes 0 to 7 and resets to 2, other trips only
// R04 - code 0 while command and output frequency differ by at most half bandwidth
// R05 - level and bandwidth 0 to 200 Hz, default 30 and 10, not above max frequency
// R06 - code 1 when command equals detect level and code 0 holds
// R07 - code 2 while detect level and run frequency differ by at most half bandwidth
// R08 - code 3 at or above level accelerating, above level minus half bandwidth decelerating
// R09 - code 4 is the inverse of code 3, a normally closed contact
// R10 - code 8 on DC bus high trip above 400 volts
// R11 - code 9 on DC bus low trip below 200 volts
// R12 - code 10 while heatsink overheat is flagged
// R13 - code 11 when the analogue or serial frequency command is lost
// R14 - code 12 while run command present and output voltage applied
// R15 - code 13 while stopped with no run command
// R16 - code 14 while running at constant speed
// R17 - code 16 while waiting for a run command from external sequence
// R18 - selected source re-evaluated every cycle and registered onto relay output
// R19 - codes 6 and 7 pass overload and stall hold; codes 5 and 15 keep relay off
module drive_status_relay_select
    import relay_select_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // frequencies and run state
    input  wire logic [15:0] cmd_freq,
    input  wire logic [15:0] out_freq,
    input  wire logic        accelerating,
    input  wire logic        decelerating,
    input  wire logic        run_cmd,
    input  wire logic        output_active,
    input  wire logic        wait_run,
    // protective flags
    input  wire logic        trip_dc_high,
    input  wire logic        trip_dc_low,
    input  wire logic        trip_other,
    input  wire logic        restart_count_set,
    input  wire logic        heatsink_hot,
    input  wire logic        drive_overload,
    input  wire logic        stall_hold,
    input  wire logic        command_lost,
    // outputs
    output logic             relay_drive,
    output logic             irq
);

    // ======================================================================
    // configuration state
    logic [4:0]           output_source_select;
    fault_mask_t          fault_relay_mask;
    freq_t                detect_level_freq;
    freq_t                detect_bandwidth;
    freq_t                max_frequency_limit;
    logic [`IRQ_BITS-1:0] irq_status;
    logic [`IRQ_BITS-1:0] irq_enable;

    // ======================================================================
    // register decode
    wire wr_ctrl   = wr && (addr == `OFS_CTRL);
    wire wr_level  = wr && (addr == `OFS_LEVEL);
    wire wr_bw     = wr && (addr == `OFS_BANDWIDTH);
    wire wr_maxf   = wr && (addr == `OFS_MAX_FREQ);
    wire wr_iclr   = wr && (addr == `OFS_IRQ_CLEAR);
    wire wr_ien    = wr && (addr == `OFS_IRQ_ENABLE);

    wire [4:0]  wr_sel   = wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
    wire [2:0]  wr_mask  = wdata[`CTRL_MASK_MSB:`CTRL_MASK_LSB];
    wire freq_t wr_freq  = wdata[15:0];
    wire        wr_hi_zero = (wdata[31:16] == 16'h0000);

    // ======================================================================
    // write acceptance
    // an out-of-range value leaves the old setting in place; a control write with a bad select still loads the mask
    wire sel_ok   = (wr_sel <= `SEL_MAX);                                        // [R01]
    wire freq_ok  = wr_hi_zero && (wr_freq <= `FREQ_CEILING)
                    && (wr_freq <= max_frequency_limit);                         // [R05]
    wire maxf_ok  = wr_hi_zero && (wr_freq <= `FREQ_CEILING);

    wire reject   = (wr_ctrl && !sel_ok)
                    || ((wr_level || wr_bw) && !freq_ok)
                    || (wr_maxf && !maxf_ok);

    wire [4:0]  next_sel   = (wr_ctrl && sel_ok) ? wr_sel : output_source_select;
    // the mask field is three bits, so every value 0 to 7 is legal
    wire [2:0]  next_mask  = wr_ctrl ? wr_mask : fault_relay_mask;               // [R03]
    wire freq_t next_level = (wr_level && freq_ok) ? wr_freq : detect_level_freq;
    wire freq_t next_bw    = (wr_bw && freq_ok) ? wr_freq : detect_bandwidth;
    wire freq_t next_maxf  = (wr_maxf && maxf_ok) ? wr_freq : max_frequency_limit;

    always_ff @(posedge mclk) begin
        if (rst) begin
            output_source_select <= `SEL_RESET;                                  // [R01]
            fault_relay_mask     <= `MASK_RESET;                                 // [R03]
            detect_level_freq    <= `LEVEL_RESET;                                // [R05]
            detect_bandwidth     <= `BANDWIDTH_RESET;                            // [R05]
            max_frequency_limit  <= `MAX_FREQ_RESET;
        end else begin
            output_source_select <= next_sel;
            fault_relay_mask     <= next_mask;
            detect_level_freq    <= next_level;
            detect_bandwidth     <= next_bw;
            max_frequency_limit  <= next_maxf;
        end
    end

    // ======================================================================
    // frequency detection
    freq_detect_if fd_bus ();

    assign fd_bus.cmd_freq     = cmd_freq;
    assign fd_bus.run_freq     = out_freq;
    assign fd_bus.level        = detect_level_freq;
    assign fd_bus.bandwidth    = detect_bandwidth;
    assign fd_bus.accelerating = accelerating;
    assign fd_bus.decelerating = decelerating;

    freq_detect u_freq_detect (
        .fd (fd_bus.detector)
    );

    // ======================================================================
    // source vector, bit n is source code n
    wire fault_output = (fault_relay_mask[`MASK_DC_LOW]     && trip_dc_low)
                      || (fault_relay_mask[`MASK_OTHER_TRIP] && trip_other)
                      || (fault_relay_mask[`MASK_RESTART]    && restart_count_set); // [R02]

    wire [17:0] src_vec;

    assign src_vec[src_freq_match_window]        = fd_bus.flags[0];              // [R04]
    assign src_vec[src_freq_level_match]         = fd_bus.flags[1];              // [R06]
    assign src_vec[src_run_near_level]           = fd_bus.flags[2];              // [R07]
    assign src_vec[src_run_above_level]          = fd_bus.flags[3];              // [R08]
    assign src_vec[src_run_above_level_inverted] = fd_bus.flags[4];              // [R09]
    assign src_vec[src_unassigned_5]             = 1'b0;                         // [R19]
    assign src_vec[src_drive_overload]           = drive_overload;               // [R19]
    assign src_vec[src_stall_hold]               = stall_hold;                   // [R19]
    assign src_vec[src_dc_high_trip]             = trip_dc_high;                 // [R10]
    assign src_vec[src_dc_low_trip]              = trip_dc_low;                  // [R11]
    assign src_vec[src_heatsink_hot]             = heatsink_hot;                 // [R12]
    assign src_vec[src_command_lost]             = command_lost;                 // [R13]
    assign src_vec[src_during_run]               = run_cmd && output_active;     // [R14]
    assign src_vec[src_during_stop]              = !run_cmd && !output_active;   // [R15]
    // constant speed means the drive is out and neither ramp is active
    assign src_vec[src_constant_run]             = output_active && !accelerating
                                                   && !decelerating;             // [R16]
    assign src_vec[src_unassigned_15]            = 1'b0;                         // [R19]
    assign src_vec[src_wait_run]                 = wait_run;                     // [R17]
    assign src_vec[src_fault_output]             = fault_output;                 // [R02]

    // ======================================================================
    // relay drive
    // the select register never holds a code above 17, so the index is safe
    wire next_relay = src_vec[output_source_select];                             // [R01]

    always_ff @(posedge mclk) begin
        if (rst) begin
            relay_drive <= 1'b0;
        end else begin
            relay_drive <= next_relay;                                           // [R18]
        end
    end

    // ======================================================================
    // interrupts
    // events are edges of the registered relay and rejected writes
    logic relay_prev;

    wire [`IRQ_BITS-1:0] irq_events;

    assign irq_events[`IRQ_RELAY_ON]  = relay_drive && !relay_prev;
    assign irq_events[`IRQ_RELAY_OFF] = !relay_drive && relay_prev;
    assign irq_events[`IRQ_REJECT]    = reject;

    wire [`IRQ_BITS-1:0] clr_bits = wr_iclr ? wdata[`IRQ_BITS-1:0] : '0;
    // a new event in the clearing cycle survives the clear
    wire [`IRQ_BITS-1:0] next_irq_status = (irq_status & ~clr_bits) | irq_events;
    wire [`IRQ_BITS-1:0] next_irq_enable = wr_ien ? wdata[`IRQ_BITS-1:0] : irq_enable;
    wire                 next_irq        = |(next_irq_status & next_irq_enable);

    always_ff @(posedge mclk) begin
        if (rst) begin
            relay_prev <= 1'b0;
            irq_status <= '0;
            irq_enable <= '0;
            irq        <= 1'b0;
        end else begin
            relay_prev <= relay_drive;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq        <= next_irq;
        end
    end

    // ======================================================================
    // read back
    wire [31:0] ctrl_word  = {21'h000000, fault_relay_mask, 3'h0, output_source_select};
    wire [31:0] state_word = {relay_drive, 13'h0000, src_vec};

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (addr)
            `OFS_CTRL:       rd_mux = ctrl_word;
            `OFS_LEVEL:      rd_mux = {16'h0000, detect_level_freq};
            `OFS_BANDWIDTH:  rd_mux = {16'h0000, detect_bandwidth};
            `OFS_MAX_FREQ:   rd_mux = {16'h0000, max_frequency_limit};
            `OFS_STATE:      rd_mux = state_word;
            `OFS_IRQ_STATUS: rd_mux = {29'h00000000, irq_status};
            `OFS_IRQ_ENABLE: rd_mux = {29'h00000000, irq_enable};
            // clear register is write-only and unmapped addresses read zero
            default:         rd_mux = 32'h00000000;
        endcase
    end

    // data stand only in the cycle after the strobe
    wire [31:0] next_rdata = rd ? rd_mux : 32'h00000000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

/* core/freq_detect.sv */
// Purpose: the five frequency detection comparators
// Assumes: all frequencies share one unit
// Notes:   half bandwidth truncates toward zero in the frequency unit
`default_nettype none

module freq_detect
    import relay_select_pkg::*;
(
    freq_detect_if.detector fd
);

    // ======================================================================
    // arithmetic
    function automatic freq_t abs_diff(input freq_t a, input freq_t b);
        abs_diff = (a >= b) ? a - b : b - a;
    endfunction

    wire freq_t half_bw      = fd.bandwidth >> 1;
    wire freq_t cmd_out_gap  = abs_diff(fd.cmd_freq, fd.run_freq);
    wire freq_t lvl_run_gap  = abs_diff(fd.level, fd.run_freq);
    // floor at zero so a narrow level never wraps the lower threshold
    wire freq_t decel_thresh = (fd.level > half_bw) ? fd.level - half_bw : 16'h0000;

    // ======================================================================
    // comparators
    wire match_window = (cmd_out_gap <= half_bw);                               // [R04]
    wire level_match  = (fd.cmd_freq == fd.level) && match_window;              // [R06]
    wire near_level   = (lvl_run_gap <= half_bw);                               // [R07]
    // outside deceleration the plain level compare applies, constant run included
    wire above_level  = fd.decelerating ? (fd.run_freq > decel_thresh)
                                        : (fd.run_freq >= fd.level);             // [R08]

    assign fd.flags = {~above_level, above_level, near_level, level_match, match_window}; // [R09]

endmodule

`default_nettype wire

/* core/freq_detect_if.sv */
// Purpose: carries frequencies and detector results between selector and detector
// Assumes: single clock domain, purely combinational detector
// Notes:   flags bit n is source code n for n = 0 to 4
`default_nettype none

interface freq_detect_if;
    import relay_select_pkg::*;

    freq_t      cmd_freq;
    freq_t      run_freq;
    freq_t      level;
    freq_t      bandwidth;
    logic       accelerating;
    logic       decelerating;
    logic [4:0] flags;

    modport selector (output cmd_freq, run_freq, level, bandwidth, accelerating, decelerating,
                      input flags);
    modport detector (input cmd_freq, run_freq, level, bandwidth, accelerating, decelerating,
                      output flags);
endinterface

`default_nettype wire

/* core/relay_select_defs.svh */
// Purpose: offsets, field positions, reset values and limits for the relay source selector
// Assumes: frequencies in units of 0.1 Hz, 16 bits wide
// Notes:   registers are 32-bit words at byte offsets that are multiples of four
`ifndef RELAY_SELECT_DEFS_SVH
`define RELAY_SELECT_DEFS_SVH

// ==========================================================================
// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_LEVEL       8'h04
`define OFS_BANDWIDTH   8'h08
`define OFS_MAX_FREQ    8'h0C
`define OFS_STATE       8'h10
`define OFS_IRQ_STATUS  8'h14
`define OFS_IRQ_CLEAR   8'h18
`define OFS_IRQ_ENABLE  8'h1C

// ==========================================================================
// field positions
`define CTRL_SEL_LSB    0
`define CTRL_SEL_MSB    4
`define CTRL_MASK_LSB   8
`define CTRL_MASK_MSB   10
`define MASK_DC_LOW     0
`define MASK_OTHER_TRIP 1
`define MASK_RESTART    2
`define IRQ_RELAY_ON    0
`define IRQ_RELAY_OFF   1
`define IRQ_REJECT      2
`define IRQ_BITS        3
`define STATE_RELAY     31

// ==========================================================================
// reset values and limits
`define SEL_MAX         5'h11
`define SEL_RESET       5'h11
`define MASK_RESET      3'h2
`define LEVEL_RESET     16'h012C
`define BANDWIDTH_RESET 16'h0064
`define MAX_FREQ_RESET  16'h0258
`define FREQ_CEILING    16'h07D0

`endif

/* core/relay_select_pkg.sv */
// Purpose: types shared by the relay source selector and its frequency detector
// Assumes: nothing beyond the defs header
// Notes:   enum order follows the source codes 0 to 17
`default_nettype none

package relay_select_pkg;

    typedef logic [15:0] freq_t;
    typedef logic [2:0]  fault_mask_t;

    typedef enum logic [4:0] {
        src_freq_match_window,
        src_freq_level_match,
        src_run_near_level,
        src_run_above_level,
        src_run_above_level_inverted,
        src_unassigned_5,
        src_drive_overload,
        src_stall_hold,
        src_dc_high_trip,
        src_dc_low_trip,
        src_heatsink_hot,
        src_command_lost,
        src_during_run,
        src_during_stop,
        src_constant_run,
        src_unassigned_15,
        src_wait_run,
        src_fault_output
    } source_e;

endpackage

`default_nettype wire

/* tb/relay_contact_model.sv */
// Purpose: external equipment on the relay contact
// Assumes: normally open contact, no bounce
// Notes:   contact closes only while the coil is energised
`default_nettype none

module relay_contact_model (
    input  wire logic relay_drive,
    output logic      contact_closed
);
    assign contact_closed = relay_drive;
endmodule

`default_nettype wire

/* tb/relay_select_checker.sv */
// Purpose: concurrent checks on the relay selector ports
// Assumes: select and mask are mirrored from register writes
// Notes:   bound into every instance of the selector
`include "relay_select_defs.svh"
`default_nettype none

module relay_select_checker (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        trip_dc_high,
    input wire logic        trip_dc_low,
    input wire logic        trip_other,
    input wire logic        restart_count_set,
    input wire logic        heatsink_hot,
    input wire logic        drive_overload,
    input wire logic        command_lost,
    input wire logic        run_cmd,
    input wire logic        output_active,
    input wire logic        relay_drive,
    input wire logic        irq
);
    // ==========================================================================
    // mirror of select and mask, since neither is a port
    logic [4:0] sel_q;
    logic [2:0] mask_q;
    wire logic  fault_now = |(mask_q & {restart_count_set, trip_other, trip_dc_low});

    always_ff @(posedge mclk) begin
        if (rst) begin
            sel_q  <= `SEL_RESET;
            mask_q <= `MASK_RESET;
        end else if (wr && addr == `OFS_CTRL) begin
            mask_q <= wdata[10:8];
            if (wdata[4:0] <= `SEL_MAX) begin
                sel_q <= wdata[4:0];
            end
        end
    end

    // ==========================================================================
    // relay follows the selected source one edge later
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_reset_quiet: assert property ($fell(rst) |-> !relay_drive && !irq)
        else $error("relay or irq active after reset");
    a_fault_mask: assert property (sel_q == 5'h11 |=> relay_drive == $past(fault_now))
        else $error("fault output ignores mask");
    a_dc_high: assert property (sel_q == 5'h08 |=> relay_drive == $past(trip_dc_high))
        else $error("relay missed dc high trip");
    a_dc_low: assert property (sel_q == 5'h09 |=> relay_drive == $past(trip_dc_low))
        else $error("relay missed dc low trip");
    a_heat_flag: assert property (sel_q == 5'h0A |=> relay_drive == $past(heatsink_hot))
        else $error("relay missed heatsink flag");
    a_cmd_lost: assert property (sel_q == 5'h0B |=> relay_drive == $past(command_lost))
        else $error("relay missed command loss");
    a_run_state: assert property (sel_q == 5'h0C |=> relay_drive == $past(run_cmd && output_active))
        else $error("relay wrong during run");
    a_stop_state: assert property (sel_q == 5'h0D |=> relay_drive == $past(!run_cmd && !output_active))
        else $error("relay wrong during stop");
    a_overload_pass: assert property (sel_q == 5'h06 |=> relay_drive == $past(drive_overload))
        else $error("relay missed overload");
    a_unassigned_off: assert property ((sel_q == 5'h05 || sel_q == 5'h0F) |=> !relay_drive)
        else $error("unassigned code drove relay");
endmodule

bind drive_status_relay_select relay_select_checker checker_inst (
    .mclk, .rst, .addr, .wdata, .wr, .trip_dc_high, .trip_dc_low, .trip_other, .restart_count_set,
    .heatsink_hot, .drive_overload, .command_lost, .run_cmd, .output_active, .relay_drive, .irq
);

`default_nettype wire

/* tb/tb_top.sv */
// Purpose: register and relay scenarios for the relay selector
// Assumes: default level 30.0 Hz and bandwidth 10.0 Hz in 0.1 Hz units
// Notes:   relay is read through the contact model
`include "relay_select_defs.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {logic [4:0] sel; logic [4:0] r; logic [15:0] c; logic [15:0] o; logic e;} case_s;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] cmd_freq = 16'h0;
    logic [15:0] out_freq = 16'h0;
    logic [7:0]  flags = 8'h00;
    logic [4:0]  run_state = 5'h00;
    logic [31:0] rdata;
    logic        relay_drive;
    logic        irq;
    logic        contact_closed;
    int          errors = 0;
    int          num_checks = 0;
    logic [4:0]  flag_code [6] = '{5'h08, 5'h09, 5'h0A, 5'h06, 5'h07, 5'h0B};
    logic [7:0]  flag_bit [6] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80};
    // {sel, run state, command, output, expected}; run state is {wait, active, run, decel, accel}
    case_s       cases [22] = '{
        '{5'h00, 5'h00, 16'h12C, 16'h15E, 1'b1}, '{5'h00, 5'h00, 16'h12C, 16'h15F, 1'b0},
        '{5'h01, 5'h00, 16'h12C, 16'h140, 1'b1}, '{5'h01, 5'h00, 16'h12D, 16'h12D, 1'b0},
        '{5'h02, 5'h00, 16'h0, 16'hFA, 1'b1}, '{5'h02, 5'h00, 16'h0, 16'hF9, 1'b0},
        '{5'h03, 5'h01, 16'h0, 16'h12C, 1'b1}, '{5'h03, 5'h01, 16'h0, 16'h12B, 1'b0},
        '{5'h03, 5'h02, 16'h0, 16'hFB, 1'b1}, '{5'h03, 5'h02, 16'h0, 16'hFA, 1'b0},
        '{5'h04, 5'h02, 16'h0, 16'hFA, 1'b1}, '{5'h04, 5'h01, 16'h0, 16'h12C, 1'b0},
        '{5'h0C, 5'h0C, 16'h0, 16'h0, 1'b1}, '{5'h0C, 5'h04, 16'h0, 16'h0, 1'b0},
        '{5'h0D, 5'h00, 16'h0, 16'h0, 1'b1}, '{5'h0D, 5'h04, 16'h0, 16'h0, 1'b0},
        '{5'h0E, 5'h08, 16'h0, 16'h0, 1'b1}, '{5'h0E, 5'h09, 16'h0, 16'h0, 1'b0},
        '{5'h10, 5'h10, 16'h0, 16'h0, 1'b1}, '{5'h10, 5'h0F, 16'h0, 16'h0, 1'b0},
        '{5'h05, 5'h1F, 16'h0, 16'h0, 1'b0}, '{5'h0F, 5'h1F, 16'h0, 16'h0, 1'b0}};

    drive_status_relay_select drive_status_relay_select_inst (
        .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .cmd_freq, .out_freq,
        .accelerating(run_state[0]), .decelerating(run_state[1]), .run_cmd(run_state[2]),
        .output_active(run_state[3]), .wait_run(run_state[4]), .trip_dc_high(flags[0]),
        .trip_dc_low(flags[1]), .trip_other(flags[2]), .restart_count_set(flags[3]),
        .heatsink_hot(flags[4]), .drive_overload(flags[5]), .stall_hold(flags[6]),
        .command_lost(flags[7]), .relay_drive, .irq
    );
    relay_contact_model relay_contact_model_inst (.relay_drive, .contact_closed);

    initial begin
        forever #4 mclk = ~mclk;
    end

    // ==========================================================================
    // access tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic relay(input logic [7:0] f, input logic [4:0] r, input logic [15:0] c, input logic [15:0] o,
                         input logic e);
        @(posedge mclk);
        flags     <= f;
        run_state <= r;
        cmd_freq  <= c;
        out_freq  <= o;
        @(posedge mclk);
        #1;
        chk({31'h0, contact_closed}, {31'h0, e});
    endtask

    task automatic irq_is(input logic e);
        @(posedge mclk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask

    task automatic stop_test;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================================================
    // scenarios
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rd_reg(`OFS_CTRL, 32'h0000_0211);
        rd_reg(`OFS_LEVEL, 32'h0000_012C);
        rd_reg(`OFS_BANDWIDTH, 32'h0000_0064);
        rd_reg(8'h40, 32'h0);
        relay(8'h02, 5'h00, 16'h0, 16'h0, 1'b0);
        relay(8'h04, 5'h00, 16'h0, 16'h0, 1'b1);
        for (int m = 0; m < 8; m++) begin
            wr_reg(`OFS_CTRL, {21'h0, m[2:0], 3'h0, 5'h11});
            for (int b = 0; b < 3; b++) begin
                relay(8'h02 << b, 5'h00, 16'h0, 16'h0, m[b]);
            end
        end
        foreach (flag_code[i]) begin
            wr_reg(`OFS_CTRL, {27'h0, flag_code[i]});
            relay(flag_bit[i], 5'h00, 16'h0, 16'h0, 1'b1);
            relay(~flag_bit[i], 5'h1F, 16'h0, 16'h0, 1'b0);
        end
        foreach (cases[i]) begin
            wr_reg(`OFS_CTRL, {27'h0, cases[i].sel});
            relay(8'hFF, cases[i].r, cases[i].c, cases[i].o, cases[i].e);
        end
        // interrupt on relay rise: raise, mask, clear
        wr_reg(`OFS_CTRL, 32'h0000_000A);
        relay(8'h00, 5'h00, 16'h0, 16'h0, 1'b0);
        wr_reg(`OFS_IRQ_CLEAR, 32'h7);
        wr_reg(`OFS_IRQ_ENABLE, 32'h1);
        rd_reg(`OFS_IRQ_STATUS, 32'h0);
        relay(8'h10, 5'h00, 16'h0, 16'h0, 1'b1);
        irq_is(1'b1);
        wr_reg(`OFS_IRQ_ENABLE, 32'h0);
        irq_is(1'b0);
        wr_reg(`OFS_IRQ_ENABLE, 32'h1);
        irq_is(1'b1);
        wr_reg(`OFS_IRQ_CLEAR, 32'h1);
        irq_is(1'b0);
        // refused select and level writes leave old values and flag a rejection; the mask and a bandwidth equal to max frequency are taken
        wr_reg(`OFS_CTRL, 32'h0000_0512);
        rd_reg(`OFS_CTRL, 32'h0000_050A);
        wr_reg(`OFS_LEVEL, 32'h0000_0259);
        rd_reg(`OFS_LEVEL, 32'h0000_012C);
        wr_reg(`OFS_BANDWIDTH, 32'h0000_0258);
        rd_reg(`OFS_BANDWIDTH, 32'h0000_0258);
        rd_reg(`OFS_IRQ_STATUS, 32'h0000_0004);
        // source vector with heatsink set, stopped, half bandwidth now 300
        rd_reg(`OFS_STATE, 32'h8000_2415);
        // read data stand for one cycle only
        @(posedge mclk);
        #1;
        chk(rdata, 32'h0);
        stop_test;
    end

    initial begin
        #200_000;
        errors++;
        stop_test;
    end
endmodule

`default_nettype wire
